// *** cpsec_top.v ***
// processing-state and exception sequencer with APB control registers
// What this block does
// (RULE1) memory-indirect branch: read long at zero-page, keep 24
// (RULE2) odd word, long or branch address forced even
// (RULE3) 1-Mbyte modes drop top four address bits
// (RULE4) exactly one of four processing states
// (RULE5) reset beats interrupt beats trap
// (RULE6) sample interrupts at boundaries, skip after flag ops/reset
// (RULE7) trap instruction always starts trap handling
// (RULE8) reset pin low holds reset, rise starts sequence
// (RULE9) reset sets mask bit then fetches start vector
// (RULE10) no interrupts during or right after reset sequence
// (RULE11) entry pushes program counter and flags via stack pointer
// (RULE12) entry sets mask, also aux mask when enable clear
// (RULE13) entry ends by fetching vector and branching
// (RULE14) watchdog overflow also enters reset state
// (RULE15) sleep with select clear halts core, keeps registers
// (RULE16) sleep with select set enters software standby
// (RULE17) standby pin low halts core, clock, resets modules
// (RULE18) time in states, accesses two or three states
// (RULE19) on-chip memory: two states, 16-bit path; in 1-Mbyte modes timed as external area 7
// (RULE20) supporting modules: three states, 8/16-bit path; in 1-Mbyte modes timed as external area 7
// (RULE21) eight external areas, per-area two or three states
// (RULE22) vector bases are parameters, offsets are four bytes per vector number
`timescale 1ns/1ps
`default_nettype none
`include "cpsec_defines.vh"
module cpsec_top
#(
	parameter [23:0] RST_VEC = `CPSEC_RST_VEC,
	parameter [23:0] TRAP_VBASE = `CPSEC_TRAP_VBASE,
	parameter [23:0] IRQ_VBASE = `CPSEC_IRQ_VBASE
)
(
	input wire core_clk_i,
	input wire arst_n_i,
	input wire psel_i,
	input wire penable_i,
	input wire pwrite_i,
	input wire [11:0] paddr_i,
	input wire [31:0] pwdata_i,
	output reg [31:0] prdata_o,
	output reg pready_o,
	output reg pslverr_o,
	input wire chip_init_pin_n_i,
	input wire hw_standby_pin_n_i,
	input wire wdt_ovf_i,
	input wire instr_done_i,
	input wire flags_op_i,
	input wire soft_trap_op_i,
	input wire [1:0] trap_num_i,
	input wire sleep_op_i,
	input wire memind_op_i,
	input wire [7:0] memind_aa8_i,
	input wire irq_req_i,
	input wire nmi_req_i,
	input wire [5:0] irq_vnum_i,
	input wire [23:0] pc_i,
	input wire [7:0] cond_flags_i,
	input wire [23:0] stack_ptr_reg_i,
	input wire [15:0] bus_rdata_i,
	output reg [1:0] proc_state_o,
	output reg core_halt_o,
	output reg clk_halt_o,
	output reg mod_reset_o,
	output reg pc_load_o,
	output reg [23:0] pc_o,
	output reg cond_wr_o,
	output reg [7:0] cond_flags_o,
	output reg sp_wr_o,
	output reg [23:0] stack_ptr_reg_o,
	output reg bus_start_o,
	output reg [23:0] bus_addr_o,
	output reg bus_wr_o,
	output reg [15:0] bus_wdata_o,
	output reg irq_ack_o,
	output reg trap_ack_o
);
	localparam [3:0] S_RST = 4'h0;
	localparam [3:0] S_RVEC = 4'h1;
	localparam [3:0] S_EXEC = 4'h2;
	localparam [3:0] S_PUSH = 4'h3;
	localparam [3:0] S_VEC = 4'h4;
	localparam [3:0] S_MIND = 4'h5;
	localparam [3:0] S_SLEEP = 4'h6;
	localparam [3:0] S_SWSB = 4'h7;
	localparam [3:0] S_HWSB = 4'h8;

	reg [3:0] st_r;
	reg [15:0] ctrl_r;
	reg init_q_r;
	reg hw_standby_pin_n_q_r;
	reg post_rst_r;
	reg acc_busy_r;
	reg half_r;
	reg [23:0] base_r;
	reg [15:0] hi_r;
	reg [23:0] vec_r;
	reg [23:0] spc_r;
	reg [7:0] sccr_r;
	wire tmr_done_w;
	wire [23:0] acc_raw_w;
	wire [23:0] acc_eff_w;
	wire [23:0] tgt_eff_w;
	wire [23:0] rd_long_w;
	wire irq_take_w;
	wire boundary_w;
	wire rst_hold_w;
	wire m1mb_w;

	function [23:0] vec_addr;
		input [23:0] base;
		input [5:0] num;
		begin
			vec_addr = base + {16'h0000, num, 2'b00};
		end
	endfunction

	function [7:0] mask_set;
		input [7:0] cond_flags;
		input ufe;
		begin
			mask_set = cond_flags;
			mask_set[`CPSEC_CCR_I] = 1'b1;
			if (!ufe)
				mask_set[`CPSEC_CCR_UI] = 1'b1;
		end
	endfunction

	assign m1mb_w = ctrl_r[`CPSEC_CTRL_M1MB];
	assign acc_raw_w = base_r + {21'h0, half_r, 2'b00} - {22'h0, half_r, 1'b0};
	assign rd_long_w = {hi_r[7:0], bus_rdata_i}; // RULE1
	// reset pin and watchdog take precedence over everything else
	assign rst_hold_w = ~init_q_r | wdt_ovf_i; // RULE5 RULE14
	// a masked level request; the non-maskable one bypasses the flags
	assign irq_take_w = nmi_req_i | (irq_req_i & ~cond_flags_i[`CPSEC_CCR_I]
		& ~(~ctrl_r[`CPSEC_CTRL_UFE] & cond_flags_i[`CPSEC_CCR_UI]));
	assign boundary_w = instr_done_i & ~flags_op_i & ~post_rst_r; // RULE6 RULE10

	cpsec_addr_calc u_acc_addr
	(
		.addr_i(acc_raw_w),
		.align_i(1'b1),
		.m1mb_i(m1mb_w),
		.eff_o(acc_eff_w)
	);

	cpsec_addr_calc u_tgt_addr
	(
		.addr_i(rd_long_w),
		.align_i(1'b1),
		.m1mb_i(m1mb_w),
		.eff_o(tgt_eff_w)
	);

	cpsec_bus_timer u_timer
	(
		.core_clk_i(core_clk_i),
		.arst_n_i(arst_n_i),
		.start_i(bus_start_o),
		.addr_i(bus_addr_o),
		.m1mb_i(m1mb_w),
		.area_3st_i(ctrl_r[`CPSEC_CTRL_AREA_LSB+7:`CPSEC_CTRL_AREA_LSB]),
		.done_o(tmr_done_w)
	);

	// apb slave, zero wait: pready is raised for the access phase
	always @(posedge core_clk_i or negedge arst_n_i)
	begin
		if (!arst_n_i)
		begin
			ctrl_r <= `CPSEC_CTRL_RST;
			prdata_o <= 32'h00000000;
			pready_o <= 1'b0;
			pslverr_o <= 1'b0;
		end
		else
		begin
			pready_o <= psel_i & ~penable_i;
			pslverr_o <= 1'b0;
			prdata_o <= 32'h00000000;
			if (psel_i & ~penable_i)
			begin
				if (paddr_i == `CPSEC_CTRL_OFS)
					prdata_o <= {16'h0000, ctrl_r};
				else if (paddr_i == `CPSEC_STAT_OFS)
					prdata_o <= {16'h0000, cond_flags_o, post_rst_r, 1'b0,
						st_r, proc_state_o};
				else
					pslverr_o <= 1'b1;
			end
			if (psel_i & penable_i & pready_o & pwrite_i
				& (paddr_i == `CPSEC_CTRL_OFS))
				ctrl_r <= {pwdata_i[15:8], 5'h00, pwdata_i[2:0]};
		end
	end

	// pins are taken as synchronous; one stage keeps them off paths
	always @(posedge core_clk_i or negedge arst_n_i)
	begin
		if (!arst_n_i)
		begin
			init_q_r <= 1'b0;
			hw_standby_pin_n_q_r <= 1'b1;
		end
		else
		begin
			init_q_r <= chip_init_pin_n_i;
			hw_standby_pin_n_q_r <= hw_standby_pin_n_i;
		end
	end

	always @(posedge core_clk_i or negedge arst_n_i)
	begin
		if (!arst_n_i)
		begin
			st_r <= S_RST;
			post_rst_r <= 1'b1;
			acc_busy_r <= 1'b0;
			half_r <= 1'b0;
			base_r <= 24'h000000;
			hi_r <= 16'h0000;
			vec_r <= 24'h000000;
			spc_r <= 24'h000000;
			sccr_r <= 8'h00;
			proc_state_o <= `CPSEC_PS_RST;
			core_halt_o <= 1'b1;
			clk_halt_o <= 1'b0;
			mod_reset_o <= 1'b1;
			pc_load_o <= 1'b0;
			pc_o <= 24'h000000;
			cond_wr_o <= 1'b0;
			cond_flags_o <= 8'h80;
			sp_wr_o <= 1'b0;
			stack_ptr_reg_o <= 24'h000000;
			bus_start_o <= 1'b0;
			bus_addr_o <= 24'h000000;
			bus_wr_o <= 1'b0;
			bus_wdata_o <= 16'h0000;
			irq_ack_o <= 1'b0;
			trap_ack_o <= 1'b0;
		end
		else
		begin
			pc_load_o <= 1'b0;
			cond_wr_o <= 1'b0;
			sp_wr_o <= 1'b0;
			bus_start_o <= 1'b0;
			irq_ack_o <= 1'b0;
			trap_ack_o <= 1'b0;
			// word access engine: two halves, high word first
			if (st_r == S_RVEC || st_r == S_PUSH || st_r == S_VEC
				|| st_r == S_MIND)
			begin
				if (!acc_busy_r)
				begin
					acc_busy_r <= 1'b1;
					bus_start_o <= 1'b1;
					bus_addr_o <= acc_eff_w;
					bus_wr_o <= (st_r == S_PUSH);
					bus_wdata_o <= half_r ? spc_r[15:0] : {sccr_r, spc_r[23:16]};
				end
				else if (tmr_done_w)
				begin
					acc_busy_r <= 1'b0;
					half_r <= ~half_r;
					if (!half_r)
						hi_r <= bus_rdata_i;
				end
			end
			if (rst_hold_w)
			begin
				// everything aborts; mask set, modules held
				st_r <= S_RST; // RULE8
				proc_state_o <= `CPSEC_PS_RST; // RULE4
				core_halt_o <= 1'b1;
				clk_halt_o <= 1'b0;
				mod_reset_o <= 1'b1;
				acc_busy_r <= 1'b0;
				half_r <= 1'b0;
				// no access may start here: its stale done would hit the vector read
				bus_start_o <= 1'b0;
				post_rst_r <= 1'b1;
				cond_flags_o <= {1'b1, cond_flags_o[6:0]}; // RULE9
				cond_wr_o <= 1'b1;
			end
			else if (!hw_standby_pin_n_q_r)
			begin
				st_r <= S_HWSB; // RULE17
				proc_state_o <= `CPSEC_PS_PDN;
				core_halt_o <= 1'b1;
				clk_halt_o <= 1'b1;
				mod_reset_o <= 1'b1;
				acc_busy_r <= 1'b0;
				bus_start_o <= 1'b0;
				half_r <= 1'b0;
			end
			else
			begin
				case (st_r)
				S_RST:
				begin
					// leaves once neither the reset pin nor the watchdog holds it
					st_r <= S_RVEC; // RULE8
					proc_state_o <= `CPSEC_PS_EXC;
					mod_reset_o <= 1'b0;
					base_r <= RST_VEC; // RULE22
				end
				S_RVEC:
				begin
					if (acc_busy_r & tmr_done_w & half_r)
					begin
						pc_o <= tgt_eff_w; // RULE9
						pc_load_o <= 1'b1;
						st_r <= S_EXEC;
						proc_state_o <= `CPSEC_PS_EXEC;
						core_halt_o <= 1'b0;
					end
				end
				S_EXEC:
				begin
					if (instr_done_i)
						post_rst_r <= 1'b0; // RULE10
					if (boundary_w & irq_take_w)
					begin
						st_r <= S_PUSH; // RULE5 RULE6
						irq_ack_o <= 1'b1;
						vec_r <= vec_addr(IRQ_VBASE, irq_vnum_i); // RULE22
						spc_r <= pc_i;
						sccr_r <= cond_flags_i;
						base_r <= stack_ptr_reg_i - 24'h000004; // RULE11
						proc_state_o <= `CPSEC_PS_EXC;
						core_halt_o <= 1'b1;
					end
					else if (soft_trap_op_i)
					begin
						// taken whatever the mask bits say
						st_r <= S_PUSH; // RULE7
						trap_ack_o <= 1'b1;
						vec_r <= vec_addr(TRAP_VBASE, {4'h0, trap_num_i});
						spc_r <= pc_i;
						sccr_r <= cond_flags_i;
						base_r <= stack_ptr_reg_i - 24'h000004; // RULE11
						proc_state_o <= `CPSEC_PS_EXC;
						core_halt_o <= 1'b1;
					end
					else if (sleep_op_i)
					begin
						proc_state_o <= `CPSEC_PS_PDN;
						core_halt_o <= 1'b1;
						if (ctrl_r[`CPSEC_CTRL_DSS])
						begin
							st_r <= S_SWSB; // RULE16
							clk_halt_o <= 1'b1;
							mod_reset_o <= 1'b1;
						end
						else
							st_r <= S_SLEEP; // RULE15
					end
					else if (memind_op_i)
					begin
						st_r <= S_MIND;
						base_r <= {16'h0000, memind_aa8_i}; // RULE1
						core_halt_o <= 1'b1;
					end
				end
				S_PUSH:
				begin
					if (acc_busy_r & tmr_done_w & half_r)
					begin
						stack_ptr_reg_o <= base_r; // RULE11
						sp_wr_o <= 1'b1;
						cond_flags_o <= mask_set(sccr_r, ctrl_r[`CPSEC_CTRL_UFE]); // RULE12
						cond_wr_o <= 1'b1;
						base_r <= vec_r;
						st_r <= S_VEC;
					end
				end
				S_VEC:
				begin
					if (acc_busy_r & tmr_done_w & half_r)
					begin
						pc_o <= tgt_eff_w; // RULE13
						pc_load_o <= 1'b1;
						// a non-maskable request at the end of a sequence is taken at once; a maskable one goes back to execution
						if (irq_req_i & cond_flags_o[`CPSEC_CCR_I] & ~nmi_req_i)
						begin
							st_r <= S_EXEC;
							proc_state_o <= `CPSEC_PS_EXEC;
							core_halt_o <= 1'b0;
						end
						else if (nmi_req_i | irq_req_i)
						begin
							irq_ack_o <= 1'b1;
							vec_r <= vec_addr(IRQ_VBASE, irq_vnum_i);
							spc_r <= tgt_eff_w;
							sccr_r <= cond_flags_o;
							base_r <= stack_ptr_reg_o - 24'h000004;
							st_r <= S_PUSH;
						end
						else
						begin
							st_r <= S_EXEC;
							proc_state_o <= `CPSEC_PS_EXEC;
							core_halt_o <= 1'b0;
						end
					end
				end
				S_MIND:
				begin
					if (acc_busy_r & tmr_done_w & half_r)
					begin
						pc_o <= tgt_eff_w; // RULE1 RULE2 RULE3
						pc_load_o <= 1'b1;
						st_r <= S_EXEC;
						core_halt_o <= 1'b0;
					end
				end
				S_SLEEP, S_SWSB:
				begin
					// registers untouched; only an interrupt wakes the core
					if (irq_take_w)
					begin
						st_r <= S_PUSH;
						irq_ack_o <= 1'b1;
						vec_r <= vec_addr(IRQ_VBASE, irq_vnum_i);
						spc_r <= pc_i;
						sccr_r <= cond_flags_i;
						base_r <= stack_ptr_reg_i - 24'h000004;
						proc_state_o <= `CPSEC_PS_EXC;
						clk_halt_o <= 1'b0;
						mod_reset_o <= 1'b0;
					end
				end
				S_HWSB:
				begin
					// standby released: restart through the reset path
					st_r <= S_RST;
					proc_state_o <= `CPSEC_PS_RST;
					clk_halt_o <= 1'b0;
					post_rst_r <= 1'b1;
				end
				default:
				begin
					st_r <= S_RST;
					proc_state_o <= `CPSEC_PS_RST;
				end
				endcase
			end
		end
	end
endmodule // cpsec_top
`default_nettype wire

// *** cpsec_defines.vh ***
// constants for the processing-state and exception sequencer
`ifndef CPSEC_DEFINES_VH
`define CPSEC_DEFINES_VH
`define CPSEC_CTRL_OFS 12'h000
`define CPSEC_STAT_OFS 12'h004
`define CPSEC_CTRL_RST 16'h0002
`define CPSEC_CTRL_DSS 0
`define CPSEC_CTRL_UFE 1
`define CPSEC_CTRL_M1MB 2
`define CPSEC_CTRL_AREA_LSB 8
`define CPSEC_CCR_I 7
`define CPSEC_CCR_UI 6
`define CPSEC_RST_VEC 24'h000000
`define CPSEC_TRAP_VBASE 24'h000020
`define CPSEC_IRQ_VBASE 24'h00001C
`define CPSEC_RAM_LO 24'hFFF000
`define CPSEC_RAM_HI 24'hFFFEFF
`define CPSEC_MOD_LO 24'hFFFF00
`define CPSEC_MEM_STATES 2'h2
`define CPSEC_MOD_STATES 2'h3
`define CPSEC_PS_EXEC 2'h0
`define CPSEC_PS_EXC 2'h1
`define CPSEC_PS_PDN 2'h2
`define CPSEC_PS_RST 2'h3
`endif

// *** cpsec_addr_calc.v ***
// effective address forming: odd-bit forcing and 1-Mbyte truncation
`timescale 1ns/1ps
`default_nettype none
module cpsec_addr_calc
(
	input wire [23:0] addr_i,
	input wire align_i,
	input wire m1mb_i,
	output wire [23:0] eff_o
);
	wire [23:0] even_w;
	assign even_w = {addr_i[23:1], addr_i[0] & ~align_i}; // RULE2
	assign eff_o = m1mb_i ? {4'h0, even_w[19:0]} : even_w; // RULE3
endmodule // cpsec_addr_calc
`default_nettype wire

// *** cpsec_bus_timer.v ***
// access-cycle timer: two or three states per access by region
`timescale 1ns/1ps
`default_nettype none
`include "cpsec_defines.vh"
module cpsec_bus_timer
(
	input wire core_clk_i,
	input wire arst_n_i,
	input wire start_i,
	input wire [23:0] addr_i,
	input wire m1mb_i,
	input wire [7:0] area_3st_i,
	output reg done_o
);
	reg [1:0] cnt_r;
	reg [1:0] need_r;
	reg busy_r;
	wire [2:0] area_w;
	reg [1:0] need_w;
	assign area_w = m1mb_i ? addr_i[19:17] : addr_i[23:21]; // RULE21
	always @*
	begin
		if (addr_i >= `CPSEC_RAM_LO && addr_i <= `CPSEC_RAM_HI)
			need_w = `CPSEC_MEM_STATES; // RULE19
		else if (addr_i >= `CPSEC_MOD_LO)
			need_w = `CPSEC_MOD_STATES; // RULE20
		else if (area_3st_i[area_w])
			need_w = `CPSEC_MOD_STATES; // RULE21
		else
			need_w = `CPSEC_MEM_STATES;
	end
	// each state is one clock from rising edge to rising edge
	always @(posedge core_clk_i or negedge arst_n_i)
	begin
		if (!arst_n_i)
		begin
			cnt_r <= 2'h0;
			need_r <= 2'h0;
			busy_r <= 1'b0;
			done_o <= 1'b0;
		end
		else
		begin
			done_o <= 1'b0;
			if (start_i)
			begin
				cnt_r <= 2'h1;
				need_r <= need_w;
				busy_r <= 1'b1;
			end
			else if (busy_r)
			begin
				cnt_r <= cnt_r + 2'h1;
				if (cnt_r + 2'h1 == need_r)
				begin
					done_o <= 1'b1; // RULE18
					busy_r <= 1'b0;
				end
			end
		end
	end
endmodule // cpsec_bus_timer
`default_nettype wire

// *** cpsec_top_asserts.sv ***
// port-level assertions for the exception sequencer
`timescale 1ns/1ps
`default_nettype none
module cpsec_top_asserts
(
	input wire logic core_clk_i,
	input wire logic arst_n_i,
	input wire logic chip_init_pin_n_i,
	input wire logic hw_standby_pin_n_i,
	input wire logic wdt_ovf_i,
	input wire logic instr_done_i,
	input wire logic flags_op_i,
	input wire logic soft_trap_op_i,
	input wire logic sleep_op_i,
	input wire logic [23:0] stack_ptr_reg_i,
	input wire logic [1:0] proc_state_o,
	input wire logic core_halt_o,
	input wire logic clk_halt_o,
	input wire logic mod_reset_o,
	input wire logic pc_load_o,
	input wire logic [23:0] pc_o,
	input wire logic cond_wr_o,
	input wire logic [7:0] cond_flags_o,
	input wire logic sp_wr_o,
	input wire logic [23:0] stack_ptr_reg_o,
	input wire logic bus_start_o,
	input wire logic [23:0] bus_addr_o,
	input wire logic irq_ack_o,
	input wire logic trap_ack_o
);
	// no reset source active, so exec-state requests must be served
	wire quiet = chip_init_pin_n_i && hw_standby_pin_n_i && !wdt_ovf_i;
	default clocking cb @(posedge core_clk_i); endclocking
	default disable iff (!arst_n_i);
	a_pin_reset: assert property (!chip_init_pin_n_i [*2] |=> proc_state_o == 2'h3)
		else $error("reset pin low without reset state");
	a_wdt_reset: assert property (wdt_ovf_i |=> proc_state_o == 2'h3)
		else $error("watchdog overflow without reset state");
	a_exec_runs: assert property (proc_state_o == 2'h0 |-> !clk_halt_o && !mod_reset_o)
		else $error("clock or modules stopped in execution state");
	a_halt_outside: assert property (proc_state_o != 2'h0 |-> core_halt_o)
		else $error("core running outside execution state");
	a_flags_mask: assert property (cond_wr_o |-> cond_flags_o[7])
		else $error("flag write without mask bit");
	a_flagop_skip: assert property (proc_state_o == 2'h0 && instr_done_i && flags_op_i
		|=> !irq_ack_o) else $error("interrupt taken after flag op");
	a_trap_taken: assert property (proc_state_o == 2'h0 && soft_trap_op_i && !instr_done_i
		&& quiet |-> ##[1:3] trap_ack_o) else $error("trap not taken");
	a_push_sp: assert property (sp_wr_o |-> stack_ptr_reg_o == stack_ptr_reg_i - 24'h000004)
		else $error("stack pointer not lowered by four");
	a_pc_even: assert property (pc_load_o |-> !pc_o[0])
		else $error("odd branch target");
	a_sleep_stop: assert property (proc_state_o == 2'h0 && sleep_op_i && !soft_trap_op_i
		&& !instr_done_i && quiet |-> ##[1:3] proc_state_o == 2'h2) else $error("sleep ignored");
	a_hw_standby: assert property ((!hw_standby_pin_n_i && chip_init_pin_n_i && !wdt_ovf_i) [*2]
		|=> clk_halt_o && mod_reset_o && core_halt_o) else $error("standby pin not obeyed");
	a_clk_stop: assert property (clk_halt_o |-> mod_reset_o && core_halt_o)
		else $error("clock halted with modules running");
	a_mod_states: assert property (bus_start_o && bus_addr_o >= 24'hFFFF00
		|=> !bus_start_o [*3]) else $error("module access shorter than three states");
	a_mem_states: assert property (bus_start_o |=> !bus_start_o [*2])
		else $error("access shorter than two states");
	c_irq: cover property (irq_ack_o);
	c_trap: cover property (trap_ack_o);
	c_standby: cover property (clk_halt_o);
endmodule // cpsec_top_asserts
bind cpsec_top cpsec_top_asserts u_chk (.*);
`default_nettype wire

// *** cpsec_mem_model.sv ***
// far-side word memory answering the sequencer's bus accesses
`timescale 1ns/1ps
`default_nettype none
module cpsec_mem_model
(
	input wire logic core_clk_i,
	input wire logic bus_start_i,
	input wire logic [23:0] bus_addr_i,
	input wire logic bus_wr_i,
	input wire logic [15:0] bus_wdata_i,
	output logic [15:0] bus_rdata_o
);
	// low page and top page folded into one small array
	logic [15:0] mem [0:255];
	logic live_r = 1'b0;
	function automatic logic [7:0] idx(input logic [23:0] a);
		idx = {a[23], a[7:1]};
	endfunction
	always @(posedge core_clk_i)
	begin
		if (bus_start_i)
			live_r <= !bus_wr_i;
		if (bus_start_i && bus_wr_i)
			mem[idx(bus_addr_i)] <= bus_wdata_i;
	end
	// not reading: show inverted data so a stale sample cannot match
	assign bus_rdata_o = live_r ? mem[idx(bus_addr_i)] : ~mem[idx(bus_addr_i)];
endmodule // cpsec_mem_model
`default_nettype wire

// *** cpsec_top_tb.sv ***
// self-checking bench for the exception sequencer
`timescale 1ns/1ps
`default_nettype none
module cpsec_top_tb;
	logic core_clk_i = 0, arst_n_i = 0, psel_i = 0, penable_i = 0, pwrite_i = 0;
	logic [11:0] paddr_i = 12'h000;
	logic [31:0] pwdata_i = 32'h0, prdata_o, rd;
	logic pready_o, pslverr_o, err, chip_init_pin_n_i = 1, hw_standby_pin_n_i = 1;
	logic wdt_ovf_i = 0, instr_done_i = 0, flags_op_i = 0, soft_trap_op_i = 0;
	logic sleep_op_i = 0, memind_op_i = 0, irq_req_i = 0, nmi_req_i = 0;
	logic [1:0] trap_num_i = 2'h2, proc_state_o;
	logic [7:0] memind_aa8_i = 8'h41, cond_flags_i = 8'h00, cond_flags_o, last_cf;
	logic [5:0] irq_vnum_i = 6'h08;
	logic [23:0] pc_i = 24'h123456, stack_ptr_reg_i = 24'hFFF100, pc_o, stack_ptr_reg_o;
	logic [23:0] bus_addr_o;
	logic [15:0] bus_rdata_i, bus_wdata_o;
	logic core_halt_o, clk_halt_o, mod_reset_o, pc_load_o, cond_wr_o, sp_wr_o;
	logic bus_start_o, bus_wr_o, irq_ack_o, trap_ack_o;
	integer fails = 0, n_checks = 0, n_irq = 0, n_trap = 0, cyc = 0;
	cpsec_top dut (.*);
	cpsec_mem_model u_mem (.core_clk_i(core_clk_i), .bus_start_i(bus_start_o),
		.bus_addr_i(bus_addr_o), .bus_wr_i(bus_wr_o), .bus_wdata_i(bus_wdata_o),
		.bus_rdata_o(bus_rdata_i));
	always #5 core_clk_i = ~core_clk_i;
	task report_and_stop;
		$display("checks %0d mismatches %0d", n_checks, fails);
		if (fails == 0 && n_checks > 0)
			$display("Test passed");
		else
			$display("Test failed");
		$finish;
	endtask
	// pulses counted at the falling edge, clear of the updating edge
	always @(negedge core_clk_i)
	begin
		if (irq_ack_o === 1'b1)
			n_irq++;
		if (trap_ack_o === 1'b1)
			n_trap++;
		if (cond_wr_o === 1'b1)
			last_cf = cond_flags_o;
		if (++cyc > 5000)
		begin
			fails++;
			report_and_stop;
		end
	end
	task automatic chk(input string nm, input logic [31:0] exp, input logic [31:0] got);
		n_checks++;
		if (got !== exp)
		begin
			$display("CHECK FAILED %s expected %h seen %h", nm, exp, got);
			fails++;
		end
	endtask
	task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d);
		integer k = 0;
		@(posedge core_clk_i);
		psel_i <= 1'b1;
		pwrite_i <= w;
		paddr_i <= a;
		pwdata_i <= d;
		@(posedge core_clk_i);
		penable_i <= 1'b1;
		do
			@(posedge core_clk_i);
		while (pready_o !== 1'b1 && ++k < 50);
		if (k >= 50)
			fails++;
		rd = prdata_o;
		err = pslverr_o;
		psel_i <= 1'b0;
		penable_i <= 1'b0;
	endtask
	task automatic wait_pc(input string nm, input logic [23:0] exp);
		integer k = 0;
		do
			@(negedge core_clk_i);
		while (pc_load_o !== 1'b1 && ++k < 200);
		chk(nm, {7'h0, 1'b1, exp}, {7'h0, pc_load_o, pc_o});
		repeat (3) @(posedge core_clk_i);
		$display("%s done", nm);
	endtask
	task automatic wait_ack(input logic tr, input integer t);
		integer k = 0;
		while ((tr ? n_trap : n_irq) < t && ++k < 200)
			@(negedge core_clk_i);
		chk("ack count", t, tr ? n_trap : n_irq);
		@(posedge core_clk_i);
		if (tr)
			soft_trap_op_i <= 1'b0;
		else
		begin
			irq_req_i <= 1'b0;
			nmi_req_i <= 1'b0;
		end
	endtask
	task automatic bound(input logic f, input logic irq, input logic tr);
		@(posedge core_clk_i);
		instr_done_i <= 1'b1;
		flags_op_i <= f;
		irq_req_i <= irq;
		soft_trap_op_i <= tr;
		@(posedge core_clk_i);
		instr_done_i <= 1'b0;
		flags_op_i <= 1'b0;
		repeat (3) @(posedge core_clk_i);
	endtask
	task automatic doze(input logic [31:0] ctl, input string nm, input logic [4:0] exp);
		apb(1'b1, 12'h000, ctl);
		sleep_op_i <= 1'b1;
		@(posedge core_clk_i);
		sleep_op_i <= 1'b0;
		repeat (3) @(negedge core_clk_i);
		chk(nm, exp, {proc_state_o, core_halt_o, clk_halt_o, mod_reset_o});
		@(posedge core_clk_i);
		nmi_req_i <= 1'b1;
	endtask
	initial
	begin
		u_mem.mem[8'h00] = 16'h0012;
		u_mem.mem[8'h01] = 16'h3457;
		u_mem.mem[8'h1E] = 16'h0000;
		u_mem.mem[8'h1F] = 16'h2000;
		u_mem.mem[8'h14] = 16'h0000;
		u_mem.mem[8'h15] = 16'h3001;
		u_mem.mem[8'h20] = 16'hABF2;
		u_mem.mem[8'h21] = 16'h3457;
		repeat (4) @(posedge core_clk_i);
		@(negedge core_clk_i);
		chk("in reset", {2'h3, 3'h5, 8'h80}, {proc_state_o, core_halt_o, clk_halt_o,
			mod_reset_o, cond_flags_o});
		@(posedge core_clk_i);
		arst_n_i <= 1'b1;
		wait_pc("reset vector", 24'h123456);
		apb(1'b0, 12'h000, 32'h0);
		chk("ctrl reset", 32'h2, rd);
		apb(1'b0, 12'h004, 32'h0);
		chk("status", {8'h80, 1'b1, 2'h0}, {rd[15:7], rd[1:0]});
		apb(1'b1, 12'h000, 32'hFFFFFFFF);
		apb(1'b0, 12'h000, 32'h0);
		chk("ctrl bits", 32'hFF07, rd);
		apb(1'b0, 12'h008, 32'h0);
		chk("unmapped", 32'h1, {rd[30:0], err});
		apb(1'b1, 12'h000, 32'h2);
		bound(1'b0, 1'b1, 1'b0);
		chk("first boundary", 0, n_irq);
		bound(1'b1, 1'b1, 1'b0);
		chk("flag op boundary", 0, n_irq);
		bound(1'b0, 1'b1, 1'b0);
		wait_ack(1'b0, 1);
		wait_pc("irq entry", 24'h002000);
		chk("irq mask", 8'h80, last_cf);
		chk("push high", 16'h0012, u_mem.mem[8'hFE]);
		chk("push low", 16'h3456, u_mem.mem[8'hFF]);
		// aux mask enable cleared, stack in module space for three-state pushes
		apb(1'b1, 12'h000, 32'h0);
		stack_ptr_reg_i <= 24'hFFFF80;
		cond_flags_i <= 8'h05;
		soft_trap_op_i <= 1'b1;
		wait_ack(1'b1, 1);
		wait_pc("trap entry", 24'h003000);
		chk("trap masks", 8'hC5, last_cf);
		chk("push flags", 16'h0512, u_mem.mem[8'hBE]);
		bound(1'b0, 1'b1, 1'b1);
		wait_ack(1'b0, 2);
		chk("trap held back", 1, n_trap);
		wait_pc("irq over trap", 24'h002000);
		wait_ack(1'b1, 2);
		wait_pc("held trap", 24'h003000);
		apb(1'b1, 12'h000, 32'h6);
		memind_op_i <= 1'b1;
		@(posedge core_clk_i);
		memind_op_i <= 1'b0;
		wait_pc("indirect", 24'h023456);
		doze(32'h2, "sleep", 5'h14);
		wait_ack(1'b0, 3);
		wait_pc("sleep wake", 24'h002000);
		doze(32'h3, "soft standby", 5'h17);
		wait_ack(1'b0, 4);
		wait_pc("standby wake", 24'h002000);
		hw_standby_pin_n_i <= 1'b0;
		repeat (3) @(negedge core_clk_i);
		chk("hw standby", 5'h17, {proc_state_o, core_halt_o, clk_halt_o, mod_reset_o});
		@(posedge core_clk_i);
		hw_standby_pin_n_i <= 1'b1;
		wait_pc("standby exit", 24'h123456);
		wdt_ovf_i <= 1'b1;
		@(posedge core_clk_i);
		wdt_ovf_i <= 1'b0;
		@(negedge core_clk_i);
		chk("watchdog", 2'h3, proc_state_o);
		wait_pc("watchdog exit", 24'h123456);
		chip_init_pin_n_i <= 1'b0;
		repeat (3) @(negedge core_clk_i);
		chk("pin reset", 4'hF, {proc_state_o, core_halt_o, cond_flags_o[7]});
		@(posedge core_clk_i);
		chip_init_pin_n_i <= 1'b1;
		wait_pc("pin release", 24'h123456);
		report_and_stop;
	end
endmodule // cpsec_top_tb
`default_nettype wire
